// ---- srwc_top.sv ----
// srwc_top: sysref window capture, phase map and frame counter reset
// assumes tap samples are synchronous to sys_clk and registers on plain port
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module srwc_top #(
    parameter int POSITIONS = 24,
    parameter int CNT_W     = 8
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [11:0]          reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]           reg_rdata,
    input  wire logic [POSITIONS-1:0] tap_coarse,
    input  wire logic [POSITIONS-1:0] tap_fine,
    input  wire logic                 single_ended_clock_in,
    output logic                 sysref_captured,
    output logic                 frame_counter_reset,
    output logic [CNT_W-1:0]     frame_count
);
    import srwc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    srwc_bus_t            bus;
    srwc_cfg_t            cfg_q;
    logic                 arm_q;
    logic [7:0]           link_format_setting_q;
    logic [CNT_W-1:0]     period_q;
    logic [POSITIONS-1:0] taps;
    logic                 picked;
    logic                 picked_prev_q;
    logic [POSITIONS-1:0] seen_hi_q;
    logic [POSITIONS-1:0] seen_lo_q;
    logic [POSITIONS-1:0] sysref_phase_map_q;
    logic                 map_valid_q;
    logic                 clk_sel_q;
    logic                 edge_now;

    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

    function automatic logic [7:0] map_byte(input logic [POSITIONS-1:0] m, input int idx);
        map_byte = m[idx*8 +: 8];
    endfunction

    srwc_delay_line #(
        .POSITIONS (POSITIONS)
    ) u_delay (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .tap_coarse (tap_coarse),
        .tap_fine   (tap_fine),
        .step_fine  (cfg_q.fine),
        .pick       (cfg_q.pick),
        .taps_q     (taps),
        .picked_q   (picked)
    );

    ////////////////////////////////////////////////////////////////////////
    // control writes; map offsets are not decoded here so writes drop
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cfg_q                 <= '{pick: SRWC_SEL_RST, fine: SRWC_FINE_RST,
                                       coarse_unused: 1'b0};
            arm_q                 <= 1'b0;
            link_format_setting_q <= SRWC_FMT_RST;
            period_q              <= CNT_W'(SRWC_PERIOD_RST);
        end else begin
            arm_q <= 1'b0;
            if (bus.wr) begin
                case (bus.addr)
                    SRWC_CTRL_OFS: begin
                        cfg_q.pick <= bus.wdata[SRWC_CTRL_SEL_LSB +: 4];
                        cfg_q.fine <= bus.wdata[SRWC_CTRL_FINE_BIT];
                        arm_q      <= bus.wdata[SRWC_CTRL_ARM_BIT];
                    end
                    SRWC_FMT_OFS:    link_format_setting_q <= bus.wdata;
                    SRWC_PERIOD_OFS: period_q <= CNT_W'(bus.wdata);
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position detector: once any tap has seen both levels, sysref has toggled
    // and the map is flagged valid; rearm clears the history
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            seen_hi_q <= '0;
            seen_lo_q <= '0;
        end else if (arm_q) begin
            seen_hi_q <= '0;
            seen_lo_q <= '0;
        end else begin
            seen_hi_q <= seen_hi_q | taps;
            seen_lo_q <= seen_lo_q | ~taps;
        end
    end

    // risk = this tap disagrees with a neighbour in any sample since rearm; both end taps are always set
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sysref_phase_map_q <= '1;
            map_valid_q        <= 1'b0;
        end else begin
            for (int i = 0; i < POSITIONS; i++) begin
                if (i == 0 || i == POSITIONS-1) begin
                    sysref_phase_map_q[i] <= 1'b1;
                end else begin
                    sysref_phase_map_q[i] <= (taps[i] != taps[i-1]) ||
                                             (taps[i] != taps[i+1]) ||
                                             (sysref_phase_map_q[i] && !arm_q);
                end
            end
            map_valid_q <= arm_q ? 1'b0 : (map_valid_q | (|(seen_hi_q & seen_lo_q)));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture: rising edge of the picked tap, so a lone pulse and a
    // periodic clock both give one event per sysref rise
    assign edge_now = picked && !picked_prev_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            picked_prev_q   <= 1'b0;
            sysref_captured <= 1'b0;
            clk_sel_q       <= 1'b0;
        end else begin
            picked_prev_q   <= picked;
            sysref_captured <= edge_now;
            clk_sel_q       <= single_ended_clock_in;
        end
    end

    // frame counter restarts on every capture; free-runs over its period
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            frame_count         <= '0;
            frame_counter_reset <= 1'b0;
        end else begin
            frame_counter_reset <= edge_now;
            if (edge_now) begin
                frame_count <= '0;
            end else if (frame_count >= period_q - CNT_W'(1)) begin
                frame_count <= '0;
            end else begin
                frame_count <= frame_count + CNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                SRWC_MAP_LOW_OFS:  reg_rdata <= map_byte(sysref_phase_map_q, 0);
                SRWC_MAP_MID_OFS:  reg_rdata <= map_byte(sysref_phase_map_q, 1);
                SRWC_MAP_HIGH_OFS: reg_rdata <= map_byte(sysref_phase_map_q, 2);
                SRWC_CTRL_OFS:     reg_rdata <= {2'b00, 1'b0, cfg_q.fine, cfg_q.pick};
                SRWC_FMT_OFS:      reg_rdata <= link_format_setting_q;
                SRWC_STAT_OFS:     reg_rdata <= {5'h00, clk_sel_q, picked, map_valid_q};
                SRWC_PERIOD_OFS:   reg_rdata <= 8'(period_q);
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// ---- srwc_pkg.sv ----
// srwc_pkg: constants and types for the sysref window capture block
// assumes a single 10 MHz system clock domain
package srwc_pkg;
    localparam int          SRWC_CLK_MHZ      = 10;
    localparam int          SRWC_POSITIONS    = 24;
    localparam int          SRWC_SEL_POSITIONS = 16;
    localparam int          SRWC_ADDR_W       = 12;
    localparam logic [11:0] SRWC_MAP_LOW_OFS  = 12'h02c;
    localparam logic [11:0] SRWC_MAP_MID_OFS  = 12'h02d;
    localparam logic [11:0] SRWC_MAP_HIGH_OFS = 12'h02e;
    localparam logic [11:0] SRWC_CTRL_OFS     = 12'h030;
    localparam logic [11:0] SRWC_FMT_OFS      = 12'h031;
    localparam logic [11:0] SRWC_STAT_OFS     = 12'h032;
    localparam int          SRWC_CTRL_SEL_LSB = 0;
    localparam int          SRWC_CTRL_FINE_BIT = 4;
    localparam int          SRWC_CTRL_ARM_BIT = 5;
    localparam logic [3:0]  SRWC_SEL_RST      = 4'h0;
    localparam logic        SRWC_FINE_RST     = 1'b1;
    localparam logic [7:0]  SRWC_FMT_RST      = 8'h00;
    localparam logic [7:0]  SRWC_PERIOD_RST   = 8'h20;
    localparam logic [7:0]  SRWC_PERIOD_OFS_V = 8'h00;
    localparam logic [11:0] SRWC_PERIOD_OFS   = 12'h033;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } srwc_bus_t;

    typedef struct packed {
        logic [3:0] pick;
        logic       fine;
        logic       coarse_unused;
    } srwc_cfg_t;
endpackage

// ---- srwc_delay_line.sv ----
// srwc_delay_line: model of the tapped sampling delay chain
// assumes taps arrive as per-position samples of sysref from the analog side
`timescale 1ns/10ps
module srwc_delay_line #(
    parameter int POSITIONS = 24
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [POSITIONS-1:0] tap_coarse,
    input  wire logic [POSITIONS-1:0] tap_fine,
    input  wire logic                 step_fine,
    input  wire logic [3:0]           pick,
    output logic [POSITIONS-1:0] taps_q,
    output logic                 picked_q
);
    import srwc_pkg::*;
    logic [POSITIONS-1:0] taps_d;

    always_comb begin
        taps_d = step_fine ? tap_fine : tap_coarse;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            taps_q <= '0;
        end else begin
            taps_q <= taps_d;
        end
    end

    // only the lower sixteen taps are selectable
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            picked_q <= 1'b0;
        end else begin
            picked_q <= taps_d[pick];
        end
    end
endmodule

// ---- srwc_checker.sv ----
// srwc_checker: port-level properties of srwc_top
// assumes a bind from the bench top; watches design outputs
`timescale 1ns/10ps
module srwc_checker
    import srwc_pkg::*;
#(
    parameter int POSITIONS = 24,
    parameter int CNT_W     = 8
) (
    input wire logic                 sys_clk,
    input wire logic                 reset,
    input wire logic [11:0]          reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    input wire logic [POSITIONS-1:0] tap_coarse,
    input wire logic [POSITIONS-1:0] tap_fine,
    input wire logic                 sysref_captured,
    input wire logic                 frame_counter_reset,
    input wire logic [CNT_W-1:0]     frame_count
);
    logic [3:0] pick_q;
    logic       fine_q;
    logic       sel_tap;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pick_q <= SRWC_SEL_RST;
            fine_q <= SRWC_FINE_RST;
        end else if (reg_wr && reg_addr == SRWC_CTRL_OFS) begin
            pick_q <= reg_wdata[3:0];
            fine_q <= reg_wdata[SRWC_CTRL_FINE_BIT];
        end
    end
    assign sel_tap = fine_q ? tap_fine[pick_q] : tap_coarse[pick_q];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_FCR_PAIR: assert property (frame_counter_reset == sysref_captured)
        else $error("counter reset not paired with capture");
    AST_CNT_ZERO: assert property (sysref_captured |-> frame_count == '0)
        else $error("frame count not cleared at capture");
    AST_CAP_SINGLE: assert property (sysref_captured |=> !sysref_captured)
        else $error("capture pulse longer than one cycle");
    AST_CAP_FOLLOWS: assert property ($rose(sel_tap) |-> ##[1:4] sysref_captured)
        else $error("selected tap edge not captured");
    AST_CAP_CAUSE: assert property (sysref_captured |-> $past(sel_tap, 2) || $past(sel_tap, 3))
        else $error("capture without selected tap");
    AST_MAP_BIT0: assert property (reg_rd && reg_addr == SRWC_MAP_LOW_OFS |=> reg_rdata[0])
        else $error("map bit 0 read as zero");
    AST_MAP_BIT23: assert property (reg_rd && reg_addr == SRWC_MAP_HIGH_OFS |=> reg_rdata[7])
        else $error("map bit 23 read as zero");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    AST_RESET_OUT: assert property ($past(reset) |-> !sysref_captured)
        else $error("capture right after reset");
    cover property (sysref_captured && fine_q);
    cover property (sysref_captured && !fine_q);
    cover property (reg_rd && reg_addr == SRWC_MAP_MID_OFS);
endmodule

// ---- srwc_clkgen_model.sv ----
// srwc_clkgen_model: external clock source seen as per-position sysref samples
// assumes taps are sampled on sys_clk
`timescale 1ns/10ps
module srwc_clkgen_model #(
    parameter int PERIOD = 8
) (
    input  wire logic       sys_clk,
    input  wire logic       fire,
    input  wire logic       periodic,
    input  wire logic [4:0] edge_pos,
    output logic [23:0] tap_coarse,
    output logic [23:0] tap_fine
);
    int   cnt = 0;
    logic sref;
    logic sref_prev = 1'b0;
    // repeat every PERIOD+1 cycles, well under one 32-cycle frame
    always @(posedge sys_clk) begin
        sref_prev <= sref;
        if (fire || (periodic && cnt == 0)) begin // one pulse or a steady train
            cnt <= PERIOD;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
    assign sref = cnt > PERIOD / 2;
    // later positions already see the new level; coarse steps move twice as far
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            tap_fine[i]   = (i >= edge_pos) ? sref : sref_prev;
            tap_coarse[i] = (i >= edge_pos / 2) ? sref : sref_prev;
        end
    end
endmodule

// ---- test_sysref_window_capture.sv ----
// test_sysref_window_capture: self-checking bench for srwc_top
// assumes the clock generator model drives all tap inputs
`timescale 1ns/10ps
module test_sysref_window_capture;
    import srwc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        single_ended_clock_in = 1'b0;
    logic        fire = 1'b0;
    logic        periodic = 1'b0;
    logic [4:0]  edge_pos = 5'h06;
    logic [7:0]  reg_rdata, frame_count, rv;
    logic [23:0] tap_coarse, tap_fine, map;
    logic        sysref_captured, frame_counter_reset;
    int          bad_count = 0;
    int          total_checks = 0;
    int          n;
    always #50 sys_clk = ~sys_clk;
    srwc_top #(.POSITIONS(24), .CNT_W(8)) i_dut (.sys_clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .tap_coarse, .tap_fine, .single_ended_clock_in,
        .sysref_captured, .frame_counter_reset, .frame_count);
    srwc_clkgen_model i_gen (.sys_clk, .fire, .periodic, .edge_pos, .tap_coarse, .tap_fine);
    ////////////////////////////////////////
    task automatic conclude;
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rd_map;
        rd(SRWC_MAP_LOW_OFS, map[7:0]);
        rd(SRWC_MAP_MID_OFS, map[15:8]);
        rd(SRWC_MAP_HIGH_OFS, map[23:16]);
    endtask
    // counts capture pulses; the counter must be cleared at each one
    task automatic pulses(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            if (sysref_captured === 1'b1) begin
                n++;
                chk("count at capture", 24'h0, {16'h0, frame_count});
            end
        end
    endtask
    task automatic fire_one;
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
    endtask
    ////////////////////////////////////////
    task automatic t_regs;
        rd(SRWC_CTRL_OFS, rv);
        chk("ctrl", {19'h0, SRWC_FINE_RST, SRWC_SEL_RST}, {16'h0, rv});
        rd(12'h100, rv);
        chk("unmapped", 24'h0, {16'h0, rv});
        rd_map;
        chk("idle map", 24'hffffff, map);
        wr(SRWC_MAP_LOW_OFS, 8'h5a);
        wr(SRWC_MAP_MID_OFS, 8'h5a);
        wr(SRWC_MAP_HIGH_OFS, 8'h5a);
        rd_map;
        chk("map after write", 24'hffffff, map);
    endtask
    // fine edge sits at 5/6, coarse at 2/3; far pair must stay clear
    task automatic t_pos(input logic fine, input logic [4:0] pos, input int lo, input int far);
        wr(SRWC_CTRL_OFS, {2'b01, fine, 4'h0});
        edge_pos <= pos;
        fire_one;
        repeat (10) @(posedge sys_clk);
        rd_map;
        chk("map ends", 24'h800001, map & 24'h800001);
        chk("edge mark", 24'h1, {23'h0, map[lo] | map[lo+1]});
        chk("far clear", 24'h0, {23'h0, map[far] | map[far+1]});
    endtask
    task automatic t_cap(input logic fine, input logic [3:0] p);
        wr(SRWC_CTRL_OFS, {3'b000, fine, p});
        fire_one;
        pulses(14);
        chk("single capture", 24'h1, n[23:0]);
    endtask
    task automatic t_periodic;
        wr(SRWC_CTRL_OFS, 8'h10);
        @(posedge sys_clk);
        periodic <= 1'b1;
        pulses(45);
        chk("periodic captures", 24'h5, n[23:0]);
        @(posedge sys_clk);
        periodic <= 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask
    task automatic t_se;
        @(posedge sys_clk);
        single_ended_clock_in <= 1'b1;
        rd(SRWC_STAT_OFS, rv);
        chk("single-ended", 24'h1, {23'h0, rv[2]});
    endtask
    // mid-run power-up: software restores its stored pick from the pick-10 fine capture test
    task automatic t_reinit;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        wr(SRWC_CTRL_OFS, 8'h1a);
        rd(SRWC_CTRL_OFS, rv);
        chk("stored pick", 24'h1a, {16'h0, rv});
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs;
        t_pos(1'b1, 5'h06, 5, 2);
        t_pos(1'b0, 5'h06, 2, 5);
        for (int p = 0; p < 16; p += 5) t_cap(1'b1, p[3:0]);
        t_cap(1'b0, 4'hf);
        t_periodic;
        t_se;
        t_reinit;
        conclude;
    end
endmodule
bind srwc_top srwc_checker #(.POSITIONS(POSITIONS), .CNT_W(CNT_W)) i_chk (.sys_clk, .reset,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tap_coarse, .tap_fine,
    .sysref_captured, .frame_counter_reset, .frame_count);
